/* File: ocd_top.sv */
`timescale 1ns/1ps
// How it works
// - CMOS phase code sets true/complement drive
// - LVDS common level 700..1000 mV, reset 900
// - HCSL internal 50 ohm termination, reset on
// - Driver bias enable bit, resets to one
// - Driver type field, reset HCSL
// - Swing code, 200 mV plus 50 steps, codes E and F 875 and 900
// - LVDS amplitude bit, 350 or 400 mV
// - Divider held set while set bit low
// - Divider enabled while enable bit low
// - Enable pin pull-down bit, reset zero
// - Enable pin pull-up bit, reset one
// - Polarity bit decides enable pin level
// - Deasserted pin disables drivers, not SPI
// - Pin select one ignores the pin
// - Power-down tri-states, ignores enable controls
module ocd_top (
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    srst,
   // Register port from the serial processor port
   input  wire logic                    regWrEn,
   input  wire logic                    regRdEn,
   input  wire logic [ocd_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [ocd_pkg::DATA_W-1:0] regWrData,
   output logic      [ocd_pkg::DATA_W-1:0] regRdData,
   output logic                         regRdValid,
   // Pins and source clock
   input  wire logic                    enableChipselectPin,
   input  wire logic                    spiMode,
   input  wire logic                    synthClk,
   // Clock output driver
   output logic                         clockOutTrue,
   output logic                         clockOutComplement,
   output logic                         clockOutOeN,
   output logic                         driverEnabled,
   output ocd_pkg::ocd_drv_t            driverType,
   output logic                         biasEnable,
   output logic                         hcslTermEnable,
   output logic      [1:0]              lvdsCommonLevelSelect,
   output logic      [10:0]             lvdsCommonMv,
   output logic      [3:0]              swingCode,
   output logic      [10:0]             swingMv,
   output logic                         lvdsAmpSelect,
   output logic      [10:0]             lvdsAmpMv,
   // Reference input divider
   output logic                         dividerHoldSet,
   output logic                         dividerEnable,
   // Enable pin pad controls
   output logic                         enablePinPulldown,
   output logic                         enablePinPullup
);
   import ocd_pkg::*;

   // =========================================================
   // State
   typedef struct packed {
      logic [7:0]  modeReg;
      logic [7:0]  ampReg;
      logic [1:0]  divReg;    // {set bar, enable bar}
      logic [7:0]  oeReg;
      logic [1:0]  drvReg;    // {disable, power down}
      logic [31:0] rdData;
      logic        rdValid;
      logic        outTrue;
      logic        outComp;
      logic        outOeN;
      logic        drvOn;
      logic [10:0] cmMv;
      logic [10:0] swMv;
      logic [10:0] ampMv;
   } ocd_state_t;

   ocd_state_t q;
   ocd_state_t d;

   ocd_ctl_if ctl ();

   // =========================================================
   // Helpers
   // Swing code to millivolts; the top two codes flatten out
   function automatic logic [10:0] swingToMv(input logic [3:0] code);
      logic [10:0] mv;
      mv = 11'(SWING_BASE_MV + SWING_STEP_MV * int'(code));
      if (code == 4'hE) begin
         mv = 11'(SWING_E_MV);
      end else if (code == 4'hF) begin
         mv = 11'(SWING_F_MV);
      end
      return mv;
   endfunction : swingToMv

   // Read mux; unmapped and reserved bits read zero
   function automatic logic [31:0] readReg(input logic [2:0] a,
                                           input ocd_state_t s);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         IDX_MODE:   r[7:0] = s.modeReg;
         IDX_AMP:    r[7:0] = s.ampReg;
         IDX_PREDIV: begin
            r[DIV_SETB_BIT] = s.divReg[1];
            r[DIV_ENB_BIT]  = s.divReg[0];
         end
         IDX_OEPIN:  r[7:0] = s.oeReg;
         IDX_DRVEN:  begin
            r[DRV_STAT_BIT] = s.drvOn;
            r[DRV_DIS_BIT]  = s.drvReg[1];
            r[DRV_PD_BIT]   = s.drvReg[0];
         end
         default:    r = 32'h0000_0000;
      endcase
      return r;
   endfunction : readReg

   // =========================================================
   // Submodules
   // Feed the gating and phase logic from the held settings, the pins and the source clock
   assign ctl.pinLevel   = enableChipselectPin;
   assign ctl.spiMode    = spiMode;
   assign ctl.oePol      = q.oeReg[OE_POL_BIT];
   assign ctl.oeSel      = q.oeReg[OE_SEL_BIT];
   assign ctl.forceDis   = q.drvReg[1];
   assign ctl.powerDown  = q.drvReg[0];
   assign ctl.srcClk     = synthClk;
   assign ctl.driverType = ocd_drv_t'(q.modeReg[MODE_TYPE_LSB +: 2]);
   assign ctl.phaseSel   = ocd_phase_t'(q.modeReg[MODE_PHASE_LSB +: 2]);

   ocd_oe_gate u_gate (
      .ctl (ctl.gate)
   );

   ocd_phase_drv u_phase (
      .ctl (ctl.phase)
   );

   // =========================================================
   // Next state
   always_comb begin
      d         = q;
      d.rdValid = 1'b0;
      // Register writes; unmapped addresses are ignored
      if (regWrEn) begin
         unique case (regAddr)
            IDX_MODE:   d.modeReg = regWrData[7:0];
            IDX_AMP:    d.ampReg  = regWrData[7:0];
            IDX_PREDIV: d.divReg  = {regWrData[DIV_SETB_BIT],
                                     regWrData[DIV_ENB_BIT]};
            IDX_OEPIN:  d.oeReg   = regWrData[7:0] & OEPIN_WR_MSK;
            IDX_DRVEN:  d.drvReg  = {regWrData[DRV_DIS_BIT],
                                     regWrData[DRV_PD_BIT]};
            default:    d.modeReg = q.modeReg;
         endcase
      end
      // Reads return the value held before any write this cycle
      if (regRdEn) begin
         d.rdValid = 1'b1;
         d.rdData  = readReg(regAddr, q);
      end
      // Pin drive: power-down tri-states, disable holds a rest level
      d.drvOn   = ctl.driveEn;
      d.outOeN  = q.drvReg[0];
      d.outTrue = ctl.outTrue & ~q.drvReg[0];
      d.outComp = ctl.outComp & ~q.drvReg[0];
      // Analog figures for the driver
      d.cmMv  = 11'(LVDS_CM_BASE_MV
                + LVDS_CM_STEP_MV * int'(q.modeReg[MODE_CM_LSB +: 2]));
      d.swMv  = swingToMv(q.ampReg[AMP_SWING_LSB +: 4]);
      d.ampMv = q.ampReg[AMP_LVDS_BIT] ? 11'(LVDS_AMP_HI_MV)
                                       : 11'(LVDS_AMP_LO_MV);
   end

   // =========================================================
   // State register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         q.modeReg <= RST_MODE;
         q.ampReg  <= RST_AMP;
         q.divReg  <= RST_DIV;
         q.oeReg   <= RST_OEPIN;
         q.drvReg  <= RST_DRVEN;
         q.rdData  <= 32'h0000_0000;
         q.rdValid <= 1'b0;
         q.outTrue <= 1'b0;
         q.outComp <= 1'b0;
         q.outOeN  <= 1'b0;
         q.drvOn   <= 1'b0;
         q.cmMv    <= RST_CM_MV;
         q.swMv    <= RST_SW_MV;
         q.ampMv   <= RST_AMP_MV;
      end else begin
         q <= d;
      end
   end

   // =========================================================
   // Outputs, each straight from the state register
   assign regRdData             = q.rdData;
   assign regRdValid            = q.rdValid;
   assign clockOutTrue          = q.outTrue;
   assign clockOutComplement    = q.outComp;
   assign clockOutOeN           = q.outOeN;
   assign driverEnabled         = q.drvOn;
   assign driverType            = ocd_drv_t'(q.modeReg[MODE_TYPE_LSB +: 2]);
   assign biasEnable            = q.modeReg[MODE_BIAS_BIT];
   assign hcslTermEnable        = q.modeReg[MODE_TERM_BIT];
   assign lvdsCommonLevelSelect = q.modeReg[MODE_CM_LSB +: 2];
   assign lvdsCommonMv          = q.cmMv;
   assign swingCode             = q.ampReg[AMP_SWING_LSB +: 4];
   assign swingMv               = q.swMv;
   assign lvdsAmpSelect         = q.ampReg[AMP_LVDS_BIT];
   assign lvdsAmpMv             = q.ampMv;
   // Both divider controls are active low in the register
   assign dividerHoldSet        = ~q.divReg[1];
   assign dividerEnable         = ~q.divReg[0];
   assign enablePinPulldown     = q.oeReg[PIN_PULLDN_BIT];
   assign enablePinPullup       = q.oeReg[PIN_PULLUP_BIT];

   // =========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   logic cmosLive;
   logic pinOff;
   assign cmosLive = ctl.driveEn && ctl.driverType == DRV_CMOS;
   assign pinOff   = ~(enableChipselectPin ^ q.oeReg[OE_POL_BIT]);

   phase_same_a: assert property (
      cmosLive && ctl.phaseSel == PH_SAME && !q.drvReg[0]
      |=> clockOutTrue == $past(synthClk) && clockOutComplement == clockOutTrue)
      else $error("same-phase drive mismatch");

   phase_true_a: assert property (
      cmosLive && ctl.phaseSel == PH_TRUE_ONLY && !q.drvReg[0]
      |=> !clockOutComplement && clockOutTrue == $past(synthClk))
      else $error("true-only drive mismatch");

   cm_level_a: assert property (
      ##1 lvdsCommonMv == 11'(LVDS_CM_BASE_MV
          + LVDS_CM_STEP_MV * int'($past(lvdsCommonLevelSelect))))
      else $error("common level millivolts wrong");

   mode_write_a: assert property (
      regWrEn && regAddr == IDX_MODE
      |=> driverType == ocd_drv_t'($past(regWrData[1:0]))
          && biasEnable == $past(regWrData[MODE_BIAS_BIT]))
      else $error("mode write not applied");

   swing_step_a: assert property (
      swingCode < 4'hE
      |=> swingMv == 11'(SWING_BASE_MV + SWING_STEP_MV * int'($past(swingCode))))
      else $error("swing millivolts wrong");

   lvds_amp_a: assert property (
      lvdsAmpSelect |=> lvdsAmpMv == 11'(LVDS_AMP_HI_MV))
      else $error("lvds amplitude wrong");

   div_hold_a: assert property (
      regWrEn && regAddr == IDX_PREDIV && !regWrData[DIV_SETB_BIT]
      |=> dividerHoldSet ##1 dividerHoldSet || $past(regWrEn))
      else $error("divider not held in set");

   pin_gate_a: assert property (
      !q.oeReg[OE_SEL_BIT] && !spiMode && pinOff |=> !driverEnabled)
      else $error("deasserted pin did not disable");

   pin_ignore_a: assert property (
      q.oeReg[OE_SEL_BIT] && q.drvReg == 2'h0 |=> driverEnabled)
      else $error("pin select one still gated");

   powerdown_a: assert property (
      q.drvReg[0] |=> clockOutOeN && !driverEnabled
                      && !clockOutTrue && !clockOutComplement)
      else $error("powered-down driver not tri-stated");

   force_dis_a: assert property (
      q.drvReg[1] |=> !driverEnabled ##1 !driverEnabled || $past(regWrEn, 2))
      else $error("forced disable ignored");

   read_back_a: assert property (
      regRdEn && regAddr == IDX_OEPIN && !regWrEn
      |=> regRdValid && regRdData[7:0] == $past(q.oeReg))
      else $error("read data not returned");

   read_zero_a: assert property (
      regRdEn && regAddr > IDX_DRVEN
      |=> regRdValid && regRdData == 32'h0000_0000)
      else $error("unmapped read not zero");

   // Register writes reach their field outputs one edge later
   term_write_a: assert property (
      regWrEn && regAddr == IDX_MODE
      |=> hcslTermEnable == $past(regWrData[MODE_TERM_BIT]))
      else $error("termination bit not applied");

   amp_write_a: assert property (
      regWrEn && regAddr == IDX_AMP
      |=> swingCode == $past(regWrData[AMP_SWING_LSB +: 4])
          && lvdsAmpSelect == $past(regWrData[AMP_LVDS_BIT]))
      else $error("amplitude write not applied");

   div_enable_a: assert property (
      regWrEn && regAddr == IDX_PREDIV
      |=> dividerEnable == !$past(regWrData[DIV_ENB_BIT])
          && dividerHoldSet == !$past(regWrData[DIV_SETB_BIT]))
      else $error("divider controls not applied");

   pull_write_a: assert property (
      regWrEn && regAddr == IDX_OEPIN
      |=> enablePinPulldown == $past(regWrData[PIN_PULLDN_BIT])
          && enablePinPullup == $past(regWrData[PIN_PULLUP_BIT]))
      else $error("pull controls not applied");

   // Driver enable and phase behaviour
   pin_polarity_a: assert property (
      !q.oeReg[OE_SEL_BIT] && !spiMode && !pinOff && q.drvReg == 2'h0 |=> driverEnabled)
      else $error("asserted pin did not enable");

   spi_ignore_a: assert property (
      spiMode && q.drvReg == 2'h0 |=> driverEnabled)
      else $error("pin gating not ignored in SPI mode");

   phase_opp_a: assert property (
      cmosLive && ctl.phaseSel == PH_OPPOSITE && !q.drvReg[0]
      |=> clockOutTrue == $past(synthClk) && clockOutComplement == !clockOutTrue)
      else $error("opposite-phase drive mismatch");

   phase_comp_a: assert property (
      cmosLive && ctl.phaseSel == PH_COMP_ONLY && !q.drvReg[0]
      |=> !clockOutTrue && clockOutComplement == $past(synthClk))
      else $error("complement-only drive mismatch");

   disabled_rest_a: assert property (
      !ctl.driveEn && !q.drvReg[0]
      |=> !clockOutOeN && !clockOutTrue
          && clockOutComplement == ($past(ctl.driverType) == DRV_LVDS))
      else $error("disabled driver not at rest level");

   // Main scenarios
   cmos_run_c: cover property (cmosLive && ctl.phaseSel == PH_OPPOSITE);
   pin_off_c: cover property (!q.oeReg[OE_SEL_BIT] && !spiMode && pinOff);
   pd_c: cover property (q.drvReg[0] ##1 !q.drvReg[0]);
   lvds_c: cover property (ctl.driverType == DRV_LVDS && driverEnabled);
   spi_c: cover property (spiMode && !q.oeReg[OE_SEL_BIT] && driverEnabled);
endmodule : ocd_top

/* File: ocd_pkg.sv */
package ocd_pkg;
   // =========================================================
   // Register indices on the internal processor-port side
   localparam int         ADDR_W     = 3;
   localparam int         DATA_W     = 32;
   localparam logic [2:0] IDX_MODE   = 3'h0;
   localparam logic [2:0] IDX_AMP    = 3'h1;
   localparam logic [2:0] IDX_PREDIV = 3'h2;
   localparam logic [2:0] IDX_OEPIN  = 3'h3;
   localparam logic [2:0] IDX_DRVEN  = 3'h4;
   // =========================================================
   // Field positions
   localparam int MODE_PHASE_LSB = 6;
   localparam int MODE_CM_LSB    = 4;
   localparam int MODE_TERM_BIT  = 3;
   localparam int MODE_BIAS_BIT  = 2;
   localparam int MODE_TYPE_LSB  = 0;
   localparam int AMP_SWING_LSB  = 4;
   localparam int AMP_LVDS_BIT   = 3;
   localparam int DIV_SETB_BIT   = 22;
   localparam int DIV_ENB_BIT    = 21;
   localparam int PIN_PULLDN_BIT = 5;
   localparam int PIN_PULLUP_BIT = 4;
   localparam int OE_POL_BIT     = 3;
   localparam int OE_SEL_BIT     = 0;
   localparam int DRV_STAT_BIT   = 7;
   localparam int DRV_DIS_BIT    = 1;
   localparam int DRV_PD_BIT     = 0;
   // =========================================================
   // Values after reset and writable masks
   localparam logic [7:0]  RST_MODE     = 8'h6C;
   localparam logic [7:0]  RST_AMP      = 8'hB4;
   localparam logic [1:0]  RST_DIV      = 2'h2;
   localparam logic [7:0]  RST_OEPIN    = 8'h10;
   localparam logic [1:0]  RST_DRVEN    = 2'h0;
   localparam logic [7:0]  OEPIN_WR_MSK = 8'h39;
   // =========================================================
   // Analog figures in millivolts and ohms
   localparam int LVDS_CM_BASE_MV = 700;
   localparam int LVDS_CM_STEP_MV = 100;
   localparam int SWING_BASE_MV   = 200;
   localparam int SWING_STEP_MV   = 50;
   localparam int SWING_E_MV      = 875;
   localparam int SWING_F_MV      = 900;
   localparam int LVDS_AMP_LO_MV  = 350;
   localparam int LVDS_AMP_HI_MV  = 400;
   localparam int HCSL_TERM_OHM   = 50;
   // Driver figures after reset: common level code 2, swing code B, low amplitude
   localparam logic [10:0] RST_CM_MV  = 11'(LVDS_CM_BASE_MV + 2 * LVDS_CM_STEP_MV);
   localparam logic [10:0] RST_SW_MV  = 11'(SWING_BASE_MV + 11 * SWING_STEP_MV);
   localparam logic [10:0] RST_AMP_MV = 11'(LVDS_AMP_LO_MV);
   // =========================================================
   // Driver type and single-ended phase codes
   typedef enum logic [1:0] {
      DRV_HCSL = 2'h0, DRV_RSVD = 2'h1, DRV_LVDS = 2'h2, DRV_CMOS = 2'h3
   } ocd_drv_t;
   typedef enum logic [1:0] {
      PH_SAME = 2'h0, PH_OPPOSITE = 2'h1, PH_TRUE_ONLY = 2'h2, PH_COMP_ONLY = 2'h3
   } ocd_phase_t;
endpackage : ocd_pkg

/* File: ocd_ctl_if.sv */
`timescale 1ns/1ps
interface ocd_ctl_if;
   import ocd_pkg::*;
   // Enable gating inputs and result
   logic       pinLevel;
   logic       spiMode;
   logic       oePol;
   logic       oeSel;
   logic       forceDis;
   logic       powerDown;
   logic       driveEn;
   // Phase drive inputs and results
   logic       srcClk;
   ocd_drv_t   driverType;
   ocd_phase_t phaseSel;
   logic       outTrue;
   logic       outComp;

   modport top (output pinLevel, spiMode, oePol, oeSel, forceDis, powerDown,
                output srcClk, driverType, phaseSel,
                input  driveEn, outTrue, outComp);
   modport gate (input pinLevel, spiMode, oePol, oeSel, forceDis, powerDown,
                 output driveEn);
   modport phase (input srcClk, driverType, phaseSel, driveEn,
                  output outTrue, outComp);
endinterface : ocd_ctl_if

/* File: ocd_oe_gate.sv */
`timescale 1ns/1ps
module ocd_oe_gate (
   // Control view
   ocd_ctl_if.gate ctl
);
   import ocd_pkg::*;

   logic pinAsserted;
   logic pinAllows;

   // =========================================================
   // Pin polarity, pin selection and forced disables
   always_comb begin
      pinAsserted = ctl.pinLevel ^ ctl.oePol;
      pinAllows   = ctl.oeSel | ctl.spiMode | pinAsserted;
      ctl.driveEn = pinAllows & ~ctl.forceDis & ~ctl.powerDown;
   end
endmodule : ocd_oe_gate

/* File: ocd_phase_drv.sv */
`timescale 1ns/1ps
module ocd_phase_drv (
   // Control view
   ocd_ctl_if.phase ctl
);
   import ocd_pkg::*;

   // =========================================================
   // True and complement levels from the source clock
   always_comb begin
      ctl.outTrue = 1'b0;
      ctl.outComp = 1'b0;
      if (ctl.driveEn && ctl.driverType == DRV_CMOS) begin
         unique case (ctl.phaseSel)
            PH_SAME: begin
               ctl.outTrue = ctl.srcClk;
               ctl.outComp = ctl.srcClk;
            end
            PH_OPPOSITE: begin
               ctl.outTrue = ctl.srcClk;
               ctl.outComp = ~ctl.srcClk;
            end
            PH_TRUE_ONLY: ctl.outTrue = ctl.srcClk;
            PH_COMP_ONLY: ctl.outComp = ctl.srcClk;
         endcase
      end else if (ctl.driveEn) begin
         // Differential types always drive a true pair
         ctl.outTrue = ctl.srcClk;
         ctl.outComp = ~ctl.srcClk;
      end else if (ctl.driverType == DRV_LVDS) begin
         // Disabled LVDS rests low/high, others low/low
         ctl.outComp = 1'b1;
      end
   end
endmodule : ocd_phase_drv

/* File: ocd_top_tb.sv */
`timescale 1ns/1ps
module ocd_top_tb;
   import ocd_pkg::*;
   // ===========================================================
   // Design signals
   logic        core_clk, srst, regWrEn, regRdEn;
   logic [2:0]  regAddr;
   logic [31:0] regWrData, regRdData;
   logic        regRdValid, enableChipselectPin, spiMode, synthClk;
   logic        clockOutTrue, clockOutComplement, clockOutOeN, driverEnabled;
   ocd_drv_t    driverType;
   logic        biasEnable, hcslTermEnable, lvdsAmpSelect, dividerHoldSet, dividerEnable;
   logic        enablePinPulldown, enablePinPullup;
   logic [1:0]  lvdsCommonLevelSelect;
   logic [3:0]  swingCode;
   logic [10:0] lvdsCommonMv, swingMv, lvdsAmpMv;
   // ===========================================================
   // Model state
   logic [7:0]  mMode, mAmp, mOe, pMode, pAmp;
   logic [1:0]  mDiv, mDrv;
   logic [31:0] eRd;
   logic        eT, eC, eOeN, eEn, nEn, rdPend;
   int          chkCnt, n_mismatch, cmp_count, seed;

   ocd_top uut (
      .core_clk(core_clk), .srst(srst), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .regRdValid(regRdValid), .enableChipselectPin(enableChipselectPin),
      .spiMode(spiMode), .synthClk(synthClk), .clockOutTrue(clockOutTrue),
      .clockOutComplement(clockOutComplement), .clockOutOeN(clockOutOeN),
      .driverEnabled(driverEnabled), .driverType(driverType), .biasEnable(biasEnable),
      .hcslTermEnable(hcslTermEnable), .lvdsCommonLevelSelect(lvdsCommonLevelSelect),
      .lvdsCommonMv(lvdsCommonMv), .swingCode(swingCode), .swingMv(swingMv),
      .lvdsAmpSelect(lvdsAmpSelect), .lvdsAmpMv(lvdsAmpMv),
      .dividerHoldSet(dividerHoldSet), .dividerEnable(dividerEnable),
      .enablePinPulldown(enablePinPulldown), .enablePinPullup(enablePinPullup)
   );

   // Swing in millivolts for a code
   function automatic int swingOf(input logic [3:0] c);
      if (c == 4'hE) return 875;
      if (c == 4'hF) return 900;
      return 200 + 50 * int'(c);
   endfunction : swingOf

   // Compare one value and count it
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk

   // Verdict and end of run
   task automatic results;
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   // Clock source
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ===========================================================
   // Reference model, evaluated at each rising edge
   always @(posedge core_clk) begin
      pMode = mMode;
      pAmp = mAmp;
      if (srst) begin
         mMode = 8'h6C;
         mAmp = 8'hB4;
         mDiv = 2'h2;
         mOe = 8'h10;
         mDrv = 2'h0;
         {eT, eC, eOeN, eEn, rdPend} = 5'h0;
         chkCnt = 0;
      end else begin
         nEn = !mDrv[0] && !mDrv[1] &&
               (mOe[0] || spiMode || (enableChipselectPin ^ mOe[3]));
         eOeN = mDrv[0];
         if (!nEn) begin
            eT = 1'b0;
            eC = !mDrv[0] && (mMode[1:0] == 2'h2);
         end else if (mMode[1:0] == 2'h3) begin
            case (mMode[7:6])
               2'h0: {eT, eC} = {synthClk, synthClk};
               2'h1: {eT, eC} = {synthClk, !synthClk};
               2'h2: {eT, eC} = {synthClk, 1'b0};
               default: {eT, eC} = {1'b0, synthClk};
            endcase
         end else begin
            {eT, eC} = {synthClk, !synthClk};
         end
         rdPend = regRdEn;
         case (regAddr)
            IDX_MODE: eRd = {24'h0, mMode};
            IDX_AMP: eRd = {24'h0, mAmp};
            IDX_PREDIV: eRd = {9'h0, mDiv, 21'h0};
            IDX_OEPIN: eRd = {24'h0, mOe};
            IDX_DRVEN: eRd = {24'h0, eEn, 5'h0, mDrv};
            default: eRd = 32'h0;
         endcase
         eEn = nEn;
         if (regWrEn) begin
            case (regAddr)
               IDX_MODE: mMode = regWrData[7:0];
               IDX_AMP: mAmp = regWrData[7:0];
               IDX_PREDIV: mDiv = regWrData[22:21];
               IDX_OEPIN: mOe = regWrData[7:0] & 8'h39;
               IDX_DRVEN: mDrv = regWrData[1:0];
               default: ;
            endcase
         end
         chkCnt++;
      end
   end

   // ===========================================================
   // Output comparison at each falling edge
   always @(negedge core_clk) begin
      if (chkCnt >= 2) begin
         chk("clockOutTrue", clockOutTrue, eT);
         chk("clockOutComplement", clockOutComplement, eC);
         chk("clockOutOeN", clockOutOeN, eOeN);
         chk("driverEnabled", driverEnabled, eEn);
         chk("regRdValid", regRdValid, rdPend);
         if (rdPend) begin
            chk("regRdData", regRdData, eRd);
         end
         chk("driverType", driverType, mMode[1:0]);
         chk("biasEnable", biasEnable, mMode[2]);
         chk("hcslTermEnable", hcslTermEnable, mMode[3]);
         chk("lvdsCommonLevelSelect", lvdsCommonLevelSelect, mMode[5:4]);
         chk("lvdsCommonMv", lvdsCommonMv, 700 + 100 * int'(pMode[5:4]));
         chk("swingCode", swingCode, mAmp[7:4]);
         chk("swingMv", swingMv, swingOf(pAmp[7:4]));
         chk("lvdsAmpSelect", lvdsAmpSelect, mAmp[3]);
         chk("lvdsAmpMv", lvdsAmpMv, pAmp[3] ? 400 : 350);
         chk("dividerHoldSet", dividerHoldSet, !mDiv[1]);
         chk("dividerEnable", dividerEnable, !mDiv[0]);
         chk("enablePinPulldown", enablePinPulldown, mOe[5]);
         chk("enablePinPullup", enablePinPullup, mOe[4]);
      end
   end

   // ===========================================================
   // Stimulus: reset value sweep, then random traffic with a reset
   initial begin
      int r;
      seed = 32'h2CCC;
      n_mismatch = 0;
      cmp_count = 0;
      chkCnt = 0;
      srst = 1'b1;
      {regWrEn, regRdEn, enableChipselectPin, spiMode, synthClk} = 5'h0;
      regAddr = 3'h0;
      regWrData = 32'h0;
      repeat (16) @(negedge core_clk);
      srst = 1'b0;
      // Every index read back to back, unmapped ones too
      for (int a = 0; a < 8; a++) begin
         @(negedge core_clk);
         regRdEn = 1'b1;
         regAddr = 3'(a);
      end
      for (int i = 0; i < 4000; i++) begin
         @(negedge core_clk);
         r = $random(seed);
         srst = (i >= 2000 && i < 2004);
         regWrEn = (r[1:0] == 2'h0);
         regRdEn = (r[3:2] == 2'h0);
         regAddr = r[6:4];
         spiMode = (r[9:7] == 3'h0);
         enableChipselectPin = r[10];
         synthClk = r[11];
         regWrData = $random(seed);
      end
      @(negedge core_clk);
      results();
   end
endmodule : ocd_top_tb
